// ### verilog/slsr_status_top.v
// Lane status readback bank for lanes 3 and 4, with page select, threshold,
// event interrupt and an Avalon-MM slave with waitrequest.
// Assumes lane receiver counts and sync levels are on core_clk_in.
//
// Register map, as word indices; the byte address is four times the index:
//   0x300 link page select, read/write
//   0x4b3 lane 3 status byte, read-only
//   0x4b4 lane 4 status byte, read-only
//   0x4c0 error count threshold, read/write, resets to all ones
//   0x4c1 interrupt status, lane 3 in bits 7:0, lane 4 in bits 15:8, clears on read
//   0x4c2 interrupt mask, same layout as the status
// Unmapped or misaligned accesses answer with a slave error and read zero.
// Writes to read-only registers are dropped and answered okay.
//
// Chosen here: the Avalon-MM register port.
`include "slsr_defines.vh"

module slsr_status_top #(
  parameter NUM_LINKS = 2,
  parameter PAGE_W    = 1,
  parameter CNT_W     = 8,
  parameter ADDR_W    = 14
) (
  // Clock and reset
  input  wire                     core_clk_in,
  input  wire                     rst_in,
  // Avalon-MM slave
  input  wire [ADDR_W-1:0]        avs_address_in,
  input  wire                     avs_read_in,
  input  wire                     avs_write_in,
  input  wire [31:0]              avs_writedata_in,
  input  wire [3:0]               avs_byteenable_in,
  output reg  [31:0]              avs_readdata_out,
  output reg                      avs_waitrequest_out,
  output reg  [1:0]               avs_response_out,
  // Lane 3 receiver state, per link {disparity, symbol, control}
  input  wire [NUM_LINKS*3*CNT_W-1:0] lane3_err_count_in,
  input  wire [NUM_LINKS*5-1:0]       lane3_sync_in,
  // Lane 4 receiver state, same packing
  input  wire [NUM_LINKS*3*CNT_W-1:0] lane4_err_count_in,
  input  wire [NUM_LINKS*5-1:0]       lane4_sync_in,
  // Interrupt
  output reg                      irq_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [PAGE_W-1:0]         link_page;
  reg  [CNT_W-1:0]          error_count_threshold;
  reg  [15:0]               irq_mask;
  reg  [NUM_LINKS*8-1:0]    lane3_prev;
  reg  [NUM_LINKS*8-1:0]    lane4_prev;
  wire [NUM_LINKS*8-1:0]    lane3_link_flags;
  wire [NUM_LINKS*8-1:0]    lane4_link_flags;
  reg  [7:0]                lane3_sync_error_flags;
  reg  [7:0]                lane4_sync_error_flags;
  reg  [7:0]                lane3_event;
  reg  [7:0]                lane4_event;
  wire [7:0]                lane3_irq_status;
  wire [7:0]                lane4_irq_status;
  wire                      bus_req;
  wire                      bus_fire;
  wire                      rd_load;
  wire                      wr_fire;
  wire                      addr_aligned;
  wire [`SLSR_IDX_W-1:0]    reg_index;
  reg  [31:0]               next_readdata;
  reg                       next_hit;
  wire                      irq_stat_clear;
  integer                   l;
  integer                   m;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-link, per-lane flag bytes

  // Every link keeps its own pair of flag bytes, so a page change never has
  // to wait for the compare to rerun. The cost is one byte of flops per lane
  // and link, which is small next to the receiver that feeds it.
  genvar g;
  generate
    for (g = 0; g < NUM_LINKS; g = g + 1)
    begin : gen_link
      // Lane 3 of link g
      slsr_lane_flags #(
        .CNT_W (CNT_W)
      ) u_lane3 (
        .core_clk_in     (core_clk_in),
        .rst_in          (rst_in),
        .threshold_in    (error_count_threshold),
        .disp_count_in   (lane3_err_count_in[(g*3+2)*CNT_W +: CNT_W]),
        .symbol_count_in (lane3_err_count_in[(g*3+1)*CNT_W +: CNT_W]),
        .ctrl_count_in   (lane3_err_count_in[(g*3)*CNT_W +: CNT_W]),
        .sync_in         (lane3_sync_in[g*5 +: 5]),
        .flags_out       (lane3_link_flags[g*8 +: 8])
      );
      // Lane 4 of link g
      slsr_lane_flags #(
        .CNT_W (CNT_W)
      ) u_lane4 (
        .core_clk_in     (core_clk_in),
        .rst_in          (rst_in),
        .threshold_in    (error_count_threshold),
        .disp_count_in   (lane4_err_count_in[(g*3+2)*CNT_W +: CNT_W]),
        .symbol_count_in (lane4_err_count_in[(g*3+1)*CNT_W +: CNT_W]),
        .ctrl_count_in   (lane4_err_count_in[(g*3)*CNT_W +: CNT_W]),
        .sync_in         (lane4_sync_in[g*5 +: 5]),
        .flags_out       (lane4_link_flags[g*8 +: 8])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Page select

  // Pick the chosen link's bytes for readback. The bytes are already
  // registered, so the mux adds no latency and a new page shows on the
  // next read.
  // A page beyond the last link reads as all zero rather than aliasing
  always @*
  begin
    lane3_sync_error_flags = `SLSR_FLAGS_RST;
    lane4_sync_error_flags = `SLSR_FLAGS_RST;
    for (l = 0; l < NUM_LINKS; l = l + 1)
    begin
      if (link_page == l[PAGE_W-1:0])
      begin
        lane3_sync_error_flags = lane3_link_flags[l*8 +: 8];
        lane4_sync_error_flags = lane4_link_flags[l*8 +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Events: an error flag rising or a sync flag dropping, on any link

  // Events watch every link, so a fault on an unselected page still interrupts.
  // Error flags raise an event when they rise, sync flags when they drop; the
  // opposite edges are recovery and stay quiet. Events of all links of a lane
  // share one status bit, so software reads the pages to find the culprit.
  always @*
  begin
    lane3_event = 8'h00;
    lane4_event = 8'h00;
    for (m = 0; m < NUM_LINKS; m = m + 1)
    begin
      lane3_event = lane3_event
                  | (lane3_link_flags[m*8 +: 8] & ~lane3_prev[m*8 +: 8] & `SLSR_ERR_BITS)
                  | (~lane3_link_flags[m*8 +: 8] & lane3_prev[m*8 +: 8] & `SLSR_SYNC_BITS);
      lane4_event = lane4_event
                  | (lane4_link_flags[m*8 +: 8] & ~lane4_prev[m*8 +: 8] & `SLSR_ERR_BITS)
                  | (~lane4_link_flags[m*8 +: 8] & lane4_prev[m*8 +: 8] & `SLSR_SYNC_BITS);
    end
  end

  // Previous flag bytes for edge detection; they reset to the flags' own
  // reset value, so no false edge follows the release of reset
  always @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lane3_prev <= {NUM_LINKS{`SLSR_FLAGS_RST}};
      lane4_prev <= {NUM_LINKS{`SLSR_FLAGS_RST}};
    end
    else
    begin
      lane3_prev <= lane3_link_flags;
      lane4_prev <= lane4_link_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status, cleared by reading it

  // The clear lands on the edge that loads the read data, so the bits that a
  // read reports are exactly the bits that it clears. Clearing one edge later
  // would wipe an event that arrived on the load edge and was never reported.
  // An event on the clear edge itself stays set inside the bank.
  assign irq_stat_clear = rd_load && addr_aligned && (reg_index == `SLSR_IDX_IRQ_STAT);

  // Lane 3 events
  slsr_irq_bank #(
    .W (8)
  ) u_irq3 (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .event_in    (lane3_event),
    .clear_in    (irq_stat_clear),
    .status_out  (lane3_irq_status)
  );

  // Lane 4 events
  slsr_irq_bank #(
    .W (8)
  ) u_irq4 (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .event_in    (lane4_event),
    .clear_in    (irq_stat_clear),
    .status_out  (lane4_irq_status)
  );

  // Level interrupt, one cycle behind the sticky bits; registered so the pin
  // never glitches while the mask or status changes
  always @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_out <= 1'b0;
    else
      irq_out <= |({lane4_irq_status, lane3_irq_status} & irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the access completes

  // Every access takes two edges. The first sees the request with waitrequest
  // high, loads read data and response, and drops waitrequest. The second
  // sees waitrequest low; a write lands there and the master takes the read
  // data. A request still held after that edge counts as a new access.
  // A master may not withdraw a request while waitrequest is high, so the
  // load edge of a read is a safe point to act on it.
  assign bus_req      = avs_read_in | avs_write_in;
  assign bus_fire     = bus_req & ~avs_waitrequest_out;
  assign rd_load      = avs_read_in & avs_waitrequest_out;
  assign wr_fire      = bus_fire & avs_write_in;
  assign addr_aligned = (avs_address_in[1:0] == 2'b00);
  assign reg_index    = avs_address_in[ADDR_W-1:2];

  // Waitrequest idles high and drops for exactly the completing cycle
  always @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      avs_waitrequest_out <= 1'b1;
    else
      avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read decode

  // Status bytes are live values; only the interrupt status clears on read.
  // Upper bits of every word read as zero.
  always @*
  begin
    next_readdata = 32'h0000_0000;
    next_hit      = addr_aligned;
    case (reg_index)
      `SLSR_IDX_PAGE:
        next_readdata[PAGE_W-1:0] = link_page;
      `SLSR_IDX_LANE3:
        next_readdata[7:0] = lane3_sync_error_flags;
      `SLSR_IDX_LANE4:
        next_readdata[7:0] = lane4_sync_error_flags;
      `SLSR_IDX_THRESH:
        next_readdata[CNT_W-1:0] = error_count_threshold;
      `SLSR_IDX_IRQ_STAT:
        next_readdata[15:0] = {lane4_irq_status, lane3_irq_status};
      `SLSR_IDX_IRQ_MASK:
        next_readdata[15:0] = irq_mask;
      default:
        next_hit = 1'b0;
    endcase
    if (!next_hit)
      next_readdata = 32'h0000_0000;
  end

  // Data and response are loaded on the edge before waitrequest is seen low.
  // They then hold until the next access, which is more than the bus asks,
  // but it saves a clear path on every completion.
  always @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      avs_readdata_out <= 32'h0000_0000;
      avs_response_out <= `SLSR_RESP_OKAY;
    end
    else if (bus_req && avs_waitrequest_out)
    begin
      avs_readdata_out <= avs_read_in ? next_readdata : 32'h0000_0000;
      avs_response_out <= next_hit ? `SLSR_RESP_OKAY : `SLSR_RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Writable control registers; status bytes ignore writes

  // Page select, threshold and mask, each honouring byte enables.
  // A threshold change takes effect on the flags one edge later; software
  // that reads right after a write may still see flags of the old threshold.
  always @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      link_page             <= {PAGE_W{1'b0}};
      error_count_threshold <= `SLSR_THRESH_RST;
      irq_mask              <= `SLSR_MASK_RST;
    end
    else if (wr_fire && addr_aligned)
    begin
      case (reg_index)
        `SLSR_IDX_PAGE:
        begin
          if (avs_byteenable_in[0])
            link_page <= avs_writedata_in[PAGE_W-1:0];
        end
        `SLSR_IDX_THRESH:
        begin
          if (avs_byteenable_in[0])
            error_count_threshold <= avs_writedata_in[CNT_W-1:0];
        end
        `SLSR_IDX_IRQ_MASK:
        begin
          if (avs_byteenable_in[0])
            irq_mask[7:0] <= avs_writedata_in[7:0];
          if (avs_byteenable_in[1])
            irq_mask[15:8] <= avs_writedata_in[15:8];
        end
        default:
        begin
          link_page <= link_page;
        end
      endcase
    end
  end

endmodule

// ### pkg/slsr_defines.vh
// Constants of the serial lane status readback block.
// Assumes inclusion by bare name from every design file of the block.
`ifndef SLSR_DEFINES_VH
`define SLSR_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register indices; byte address is four times the index
`define SLSR_IDX_W        12
`define SLSR_IDX_PAGE     12'h300
`define SLSR_IDX_LANE3    12'h4b3
`define SLSR_IDX_LANE4    12'h4b4
`define SLSR_IDX_THRESH   12'h4c0
`define SLSR_IDX_IRQ_STAT 12'h4c1
`define SLSR_IDX_IRQ_MASK 12'h4c2

////////////////////////////////////////////////////////////////////////////////
// Status byte layout
`define SLSR_BIT_DISP     7
`define SLSR_BIT_SYMBOL   6
`define SLSR_BIT_CTRL     5
`define SLSR_BIT_DESKEW   4
`define SLSR_BIT_ALIGN    3
`define SLSR_BIT_CKSUM    2
`define SLSR_BIT_FRAME    1
`define SLSR_BIT_CGS      0
`define SLSR_ERR_BITS     8'he0
`define SLSR_SYNC_BITS    8'h1f

////////////////////////////////////////////////////////////////////////////////
// Reset values and bus answers
`define SLSR_FLAGS_RST    8'h00
`define SLSR_THRESH_RST   8'hff
`define SLSR_MASK_RST     16'h0000
`define SLSR_RESP_OKAY    2'b00
`define SLSR_RESP_SLVERR  2'b10

`endif

// ### verilog/slsr_lane_flags.v
// One lane of one link: threshold compare and sync flags into a status byte.
// Assumes counts and sync levels come from receiver logic on core_clk_in.
`include "slsr_defines.vh"

module slsr_lane_flags #(
  parameter CNT_W = 8
) (
  // Clock and reset
  input  wire             core_clk_in,
  input  wire             rst_in,
  // Threshold and lane receiver state
  input  wire [CNT_W-1:0] threshold_in,
  input  wire [CNT_W-1:0] disp_count_in,
  input  wire [CNT_W-1:0] symbol_count_in,
  input  wire [CNT_W-1:0] ctrl_count_in,
  input  wire [4:0]       sync_in,
  // Registered status byte
  output reg  [7:0]       flags_out
);

  reg [7:0] next_flags;

  // Compare is at-or-above, so a count equal to the threshold flags
  always @*
  begin
    next_flags = `SLSR_FLAGS_RST;
    next_flags[`SLSR_BIT_DISP]   = (disp_count_in >= threshold_in);
    next_flags[`SLSR_BIT_SYMBOL] = (symbol_count_in >= threshold_in);
    next_flags[`SLSR_BIT_CTRL]   = (ctrl_count_in >= threshold_in);
    next_flags[`SLSR_BIT_DESKEW] = sync_in[`SLSR_BIT_DESKEW];
    next_flags[`SLSR_BIT_ALIGN]  = sync_in[`SLSR_BIT_ALIGN];
    next_flags[`SLSR_BIT_CKSUM]  = sync_in[`SLSR_BIT_CKSUM];
    next_flags[`SLSR_BIT_FRAME]  = sync_in[`SLSR_BIT_FRAME];
    next_flags[`SLSR_BIT_CGS]    = sync_in[`SLSR_BIT_CGS];
  end

  // Refreshed every cycle from live state
  always @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      flags_out <= `SLSR_FLAGS_RST;
    else
      flags_out <= next_flags;
  end

endmodule

// ### verilog/slsr_irq_bank.v
// Sticky event bits, cleared by a read strobe; a new event beats the clear.
// Assumes event and clear strobes are on core_clk_in.
`include "slsr_defines.vh"

module slsr_irq_bank #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         core_clk_in,
  input  wire         rst_in,
  // Events and read-clear strobe
  input  wire [W-1:0] event_in,
  input  wire         clear_in,
  // Sticky status
  output reg  [W-1:0] status_out
);

  // Set wins over clear so no event is lost at the read edge
  always @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      status_out <= {W{1'b0}};
    else if (clear_in)
      status_out <= event_in;
    else
      status_out <= status_out | event_in;
  end

endmodule

// ### tb/slsr_lane_model.sv
// Far-side model: receiver error counts and sync levels per lane and link.
// Assumes the bench calls set_lane just after a rising edge of the clock.
module slsr_lane_model (
  // Clock
  input  wire logic   core_clk_in,
  // Per link {disparity, symbol, control} counts and sync levels
  output logic [47:0] lane3_err_out,
  output logic [9:0]  lane3_sync_out,
  output logic [47:0] lane4_err_out,
  output logic [9:0]  lane4_sync_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet receiver at start: no errors, no sync
  initial
  begin
    lane3_err_out  = 48'h0;
    lane3_sync_out = 10'h0;
    lane4_err_out  = 48'h0;
    lane4_sync_out = 10'h0;
  end

  // Counts and sync move together, so one edge never sees a half update
  task automatic set_lane(input int ln, input int lk, input logic [23:0] e, input logic [4:0] s);
    @(posedge core_clk_in);
    if (ln == 3)
    begin
      lane3_err_out[lk*24 +: 24] <= e;
      lane3_sync_out[lk*5 +: 5]  <= s;
    end
    else
    begin
      lane4_err_out[lk*24 +: 24] <= e;
      lane4_sync_out[lk*5 +: 5]  <= s;
    end
  endtask
endmodule

// ### tb/slsr_status_properties.sv
// Checker of the lane status bank: bus timing and status readback.
// Assumes it is bound to slsr_status_top and sees only its ports.
module slsr_status_properties #(
  parameter NUM_LINKS = 2,
  parameter PAGE_W    = 1,
  parameter CNT_W     = 8,
  parameter ADDR_W    = 14
) (
  // Clock, reset and bus
  input wire logic                         core_clk_in,
  input wire logic                         rst_in,
  input wire logic [ADDR_W-1:0]            avs_address_in,
  input wire logic                         avs_read_in,
  input wire logic                         avs_write_in,
  input wire logic [31:0]                  avs_writedata_in,
  input wire logic [3:0]                   avs_byteenable_in,
  input wire logic [31:0]                  avs_readdata_out,
  input wire logic                         avs_waitrequest_out,
  input wire logic [1:0]                   avs_response_out,
  // Lane receiver state and interrupt
  input wire logic [NUM_LINKS*3*CNT_W-1:0] lane3_err_count_in,
  input wire logic [NUM_LINKS*5-1:0]       lane3_sync_in,
  input wire logic [NUM_LINKS*3*CNT_W-1:0] lane4_err_count_in,
  input wire logic [NUM_LINKS*5-1:0]       lane4_sync_in,
  input wire logic                         irq_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Expected status byte of one link
  function automatic logic [7:0] lane_byte(input logic [23:0] e, input logic [4:0] s,
                                           input logic [7:0] t);
    return {e[23:16] >= t, e[15:8] >= t, e[7:0] >= t, s};
  endfunction

  logic [7:0]        thr;
  logic [PAGE_W-1:0] pg;
  logic [15:0]       ex1;
  logic [15:0]       ex2;
  wire               done = (avs_read_in | avs_write_in) & ~avs_waitrequest_out;
  wire               rd   = avs_read_in & ~avs_waitrequest_out;
  wire               rd_al = rd & (avs_address_in[1:0] == 2'h0);
  wire [11:0]        idx  = avs_address_in[13:2];
  wire [7:0]         ex3  = lane_byte(lane3_err_count_in[pg*24 +: 24],
                                      lane3_sync_in[pg*5 +: 5], thr);
  wire [7:0]         ex4  = lane_byte(lane4_err_count_in[pg*24 +: 24],
                                      lane4_sync_in[pg*5 +: 5], thr);

  // Shadow of threshold and page; two stages match flag register plus read load
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
    begin
      thr <= 8'hff;
      pg  <= '0;
      ex1 <= 16'h0;
      ex2 <= 16'h0;
    end
    else
    begin
      ex1 <= {ex4, ex3};
      ex2 <= ex1;
      if (done && avs_write_in && avs_byteenable_in[0] && avs_address_in[1:0] == 2'h0)
      begin
        if (idx == 12'h300)
          pg <= avs_writedata_in[PAGE_W-1:0];
        if (idx == 12'h4c0)
          thr <= avs_writedata_in[7:0];
      end
    end

  ////////////////////////////////////////
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  AST_IDLE_WAIT: assert property (
    !(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("waitrequest low without a request");
  AST_WAIT_ONE: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered after one wait cycle");
  AST_WAIT_PULSE: assert property (
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  AST_L3_ERR: assert property (
    rd_al && idx == 12'h4b3 |-> avs_readdata_out[7:5] == ex2[7:5])
    else $error("lane 3 error flags differ from count compare");
  AST_L3_SYNC: assert property (
    rd_al && idx == 12'h4b3 |-> avs_readdata_out[4:0] == ex2[4:0]
                                && avs_readdata_out[31:8] == 24'h0)
    else $error("lane 3 sync flags differ from receiver");
  AST_L4_BYTE: assert property (
    rd_al && idx == 12'h4b4 |-> avs_readdata_out == {24'h0, ex2[15:8]})
    else $error("lane 4 status byte wrong");
  AST_MISALIGN: assert property (
    rd && avs_address_in[1:0] != 2'h0 |-> avs_response_out == 2'h2
                                          && avs_readdata_out == 32'h0)
    else $error("misaligned read not refused");
  AST_LANE_OKAY: assert property (
    done && avs_address_in[1:0] == 2'h0 && (idx == 12'h4b3 || idx == 12'h4b4)
    |-> avs_response_out == 2'h0)
    else $error("status register access not answered okay");

  COV_PAGE1: cover property (rd && pg != '0 && idx == 12'h4b3);
  COV_IRQ: cover property ($rose(irq_out));
  COV_REFUSED: cover property (done && avs_response_out == 2'h2);
endmodule

bind slsr_status_top slsr_status_properties #(.NUM_LINKS(NUM_LINKS), .PAGE_W(PAGE_W),
  .CNT_W(CNT_W), .ADDR_W(ADDR_W)) u_props (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .avs_response_out(avs_response_out), .lane3_err_count_in(lane3_err_count_in),
  .lane3_sync_in(lane3_sync_in), .lane4_err_count_in(lane4_err_count_in),
  .lane4_sync_in(lane4_sync_in), .irq_out(irq_out));

// ### tb/testbench.sv
// Self-checking bench of the lane status bank over its Avalon-MM port.
// Assumes the lane model stands in for the receiver inputs of the bank.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [13:0] avs_address_in = 14'h0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [1:0]  avs_response_out;
  logic        irq_out;
  logic [47:0] l3_err;
  logic [9:0]  l3_sync;
  logic [47:0] l4_err;
  logic [9:0]  l4_sync;
  logic [31:0] q;
  logic [1:0]  r;
  int          error_cnt = 0;
  int          n_compared = 0;

  // Half period of 2 ns gives 250 MHz
  always #2 core_clk_in = ~core_clk_in;

  slsr_status_top u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .avs_response_out(avs_response_out), .lane3_err_count_in(l3_err),
    .lane3_sync_in(l3_sync), .lane4_err_count_in(l4_err), .lane4_sync_in(l4_sync),
    .irq_out(irq_out));

  slsr_lane_model u_lanes (.core_clk_in(core_clk_in), .lane3_err_out(l3_err),
    .lane3_sync_out(l3_sync), .lane4_err_out(l4_err), .lane4_sync_out(l4_sync));

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One access; the request stands until waitrequest is sampled low
  task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= w;
    avs_read_in      <= !w;
    // Waits as long as the slave asks; only the watchdog ends a hang
    do
    begin
      @(posedge core_clk_in);
    end
    while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    r = avs_response_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
    // Idle edges let flags and the interrupt settle before the next step
    repeat (3) @(posedge core_clk_in);
  endtask

  task automatic rd(input logic [11:0] i, input logic [31:0] e);
    bus(1'b0, {i, 2'h0}, 32'h0);
    check(q, e);
    check({30'h0, r}, 32'h0);
  endtask

  task automatic refused(input logic [13:0] a);
    bus(1'b0, a, 32'h0);
    check(q, 32'h0);
    check({30'h0, r}, 32'h2);
  endtask

  task automatic lanes(input int ln, input int lk, input logic [23:0] e, input logic [4:0] s);
    u_lanes.set_lane(ln, lk, e, s);
    repeat (5) @(posedge core_clk_in);
  endtask

  ////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd(12'h4b3, 32'h0);
    rd(12'h4b4, 32'h0);
    rd(12'h4c0, 32'hff);
    // Counts just at, below and above the threshold, every flag both ways
    bus(1'b1, {12'h4c0, 2'h0}, 32'h10);
    lanes(3, 0, 24'h100f11, 5'h15);
    rd(12'h4b3, 32'hb5);
    rd(12'h4b3, 32'hb5);
    lanes(3, 0, 24'h0f100f, 5'h0a);
    rd(12'h4b3, 32'h4a);
    // Other link differs; only the page decides what is read
    lanes(3, 1, 24'hff0000, 5'h1f);
    lanes(4, 0, 24'h000011, 5'h03);
    lanes(4, 1, 24'h101010, 5'h10);
    rd(12'h4b4, 32'h23);
    bus(1'b1, {12'h300, 2'h0}, 32'h1);
    rd(12'h4b3, 32'h9f);
    bus(1'b1, {12'h4b4, 2'h0}, 32'h0);
    rd(12'h4b4, 32'hf0);
    bus(1'b1, {12'h300, 2'h0}, 32'h0);
    rd(12'h4b3, 32'h4a);
    refused(14'h12cd);
    refused({12'h123, 2'h0});
    // Events latch while masked and read back; once unmasked, a new event on link 1 raises the line
    bus(1'b0, {12'h4c1, 2'h0}, 32'h0);
    lanes(3, 0, 24'hff100f, 5'h0a);
    check({31'h0, irq_out}, 32'h0);
    rd(12'h4c1, 32'h80);
    bus(1'b1, {12'h4c2, 2'h0}, 32'h80);
    lanes(3, 1, 24'h000000, 5'h1f);
    lanes(3, 1, 24'hff0000, 5'h1f);
    check({31'h0, irq_out}, 32'h1);
    rd(12'h4c1, 32'h80);
    check({31'h0, irq_out}, 32'h0);
    bus(1'b1, {12'h4c2, 2'h0}, 32'h280);
    rd(12'h4c2, 32'h280);
    lanes(4, 0, 24'h000011, 5'h01);
    check({31'h0, irq_out}, 32'h1);
    rd(12'h4c1, 32'h200);
    results();
  end

  // Tests take well under 1000 cycles; this span only cuts a hang short
  initial
  begin
    #25us;
    error_cnt++;
    results();
  end
endmodule
